//--- hw/arf_pkg.sv
/*
 * Constants, register map and types of the result-format and manual-sampling block.
 * Assumes a 32-bit AHB-Lite bus and a converter core that answers each start with a done pulse.
 */
// Contract
// - Each result is stored as a 10-bit code and is formatted only when the buffer is read.
// - A two-bit format field at bits 9:8 of the first control register picks the read format.
// - Every buffer read drives a full 16-bit word, whatever the format.
// - Unsigned integer puts the code in bits 9:0 with zeros above, so full scale reads 1023.
// - Signed integer returns the code minus 512 in two's complement, from -512 to 511.
// - Unsigned fractional left-justifies the code into bits 15:6 and clears bits 5:0.
// - Signed fractional inverts the top code bit and left-justifies it, 0.998 at full scale.
// - Manual sampling ignores the auto-sample duration field at bits 12:8 of the third register.
// - Software clears the sample-control bit for each sample; that clearing starts conversion.
// - A finished conversion sets the conversion-complete flag and the converter interrupt flag.
// - With the minimum interrupt count the interrupt flag is raised after every single result.
package arf_pkg;
    localparam int CODE_W = 10;
    localparam int WORD_W = 16;
    localparam int BUF_IDX_W = 4;
    localparam int BUF_IDX_LSB = 2;
    localparam int BUF_SEL_LSB = 6;
    localparam int OFF_W = 12;
    localparam int ASD_W = 5;
    localparam logic [OFF_W-1:0] OFF_CTRL1 = 12'h000;
    localparam logic [OFF_W-1:0] OFF_CTRL3 = 12'h004;
    localparam logic [OFF_W-1:0] OFF_STATUS = 12'h008;
    localparam logic [OFF_W-1:0] OFF_MASK = 12'h00c;
    localparam logic [OFF_W-1:0] OFF_BUF = 12'h040;
    localparam int CTRL1_FMT_LSB = 8;
    localparam int CTRL1_SAMPLE_CONTROL_BIT_BIT = 1;
    localparam int CTRL1_DONE_BIT = 0;
    localparam int CTRL3_ASD_LSB = 8;
    localparam int IRQ_CONV_BIT = 0;
    localparam logic [WORD_W-1:0] SINT_OFFSET = 16'h0200;
    localparam logic [5:0] PAD_ZERO = 6'h00;

    typedef enum logic [1:0] {
        ARF_FMT_UINT = 2'h0,
        ARF_FMT_SINT = 2'h1,
        ARF_FMT_FRAC = 2'h2,
        ARF_FMT_SFRAC = 2'h3
    } arf_fmt_t;

    typedef enum logic [1:0] {
        ARF_IDLE,
        ARF_SAMPLE,
        ARF_CONVERT
    } arf_state_t;

    localparam arf_fmt_t FMT_RESET = ARF_FMT_UINT;
endpackage : arf_pkg

//--- hw/arf_fmt_if.sv
/*
 * Carrier between the buffer read port and the output formatter.
 * Assumes the formatter is purely combinational.
 */
`timescale 1ns/1ps
interface arf_fmt_if;
    logic [arf_pkg::CODE_W-1:0] code;
    arf_pkg::arf_fmt_t fmt;
    logic [arf_pkg::WORD_W-1:0] word;
    modport conv (input code, input fmt, output word);
    modport user (output code, output fmt, input word);
endinterface : arf_fmt_if

//--- hw/arf_formatter.sv
/*
 * Turns a stored 10-bit code into the selected 16-bit read presentation.
 * Assumes the code and format are stable during the address phase.
 */
`timescale 1ns/1ps
module arf_formatter (
    arf_fmt_if.conv fbus
);
    logic [arf_pkg::CODE_W-1:0] c;
    logic [arf_pkg::WORD_W-1:0] w_uint;
    logic [arf_pkg::WORD_W-1:0] w_sint;
    logic [arf_pkg::WORD_W-1:0] w_frac;
    logic [arf_pkg::WORD_W-1:0] w_sfrac;

    assign c = fbus.code;
    assign w_uint = {arf_pkg::PAD_ZERO, c};
    // Top bit inverted and sign-extended equals code minus the mid-scale offset
    assign w_sint = {{(arf_pkg::WORD_W - arf_pkg::CODE_W + 1){~c[arf_pkg::CODE_W-1]}},
                     c[arf_pkg::CODE_W-2:0]};
    assign w_frac = {c, arf_pkg::PAD_ZERO};
    assign w_sfrac = {~c[arf_pkg::CODE_W-1], c[arf_pkg::CODE_W-2:0], arf_pkg::PAD_ZERO};
    assign fbus.word = (fbus.fmt == arf_pkg::ARF_FMT_SINT) ? w_sint :
                       (fbus.fmt == arf_pkg::ARF_FMT_FRAC) ? w_frac :
                       (fbus.fmt == arf_pkg::ARF_FMT_SFRAC) ? w_sfrac : w_uint;
endmodule : arf_formatter

//--- hw/arf_top.sv
/*
 * Result buffer, output formatting, manual sample/convert control and interrupt
 * for a 10-bit converter, reached over an AHB-Lite slave port.
 * Assumes the converter core takes a one-cycle start pulse and returns one done pulse
 * with the code; single word transfers only; the one slave drives the bus ready.
 */
`timescale 1ns/1ps
module arf_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output logic SAMPLE_HOLD,
    output logic CONV_START,
    input wire logic CONV_DONE,
    input wire logic [9:0] CONV_DATA,
    output logic IRQ
);
    localparam int DEPTH = 1 << arf_pkg::BUF_IDX_W;

    arf_pkg::arf_state_t state;
    arf_pkg::arf_state_t next_state;
    arf_pkg::arf_fmt_t fmt;
    logic [arf_pkg::ASD_W-1:0] auto_sample_duration;
    logic done;
    logic irq_status;
    logic irq_mask;
    logic wr_pend;
    logic [arf_pkg::OFF_W-1:0] wr_off;
    logic [arf_pkg::BUF_IDX_W-1:0] wr_ptr;
    logic [arf_pkg::CODE_W-1:0] buf_mem [DEPTH];

    logic addr_take;
    logic rd_take;
    logic [arf_pkg::OFF_W-1:0] a_off;
    logic hit_buf;
    logic [arf_pkg::BUF_IDX_W-1:0] rd_idx;
    logic [arf_pkg::CODE_W-1:0] cur_code;
    logic [31:0] ctrl1_view;
    logic [31:0] ctrl3_view;
    logic [31:0] rd_mux;
    logic wr_ctrl1;
    logic wr_ctrl3;
    logic wr_status;
    logic wr_mask;
    logic sample_control_bit_set;
    logic sample_control_bit_clear;
    logic conv_evt;
    logic next_done;
    logic next_status;

    arf_fmt_if fmt_bus ();

    arf_formatter u_fmt (
        .fbus(fmt_bus)
    );

    // Address phase decode
    assign addr_take = HSEL & HTRANS[1] & HREADY;
    assign rd_take = addr_take & ~HWRITE;
    assign a_off = HADDR[arf_pkg::OFF_W-1:0];
    assign hit_buf = a_off[arf_pkg::OFF_W-1:arf_pkg::BUF_SEL_LSB]
                     == arf_pkg::OFF_BUF[arf_pkg::OFF_W-1:arf_pkg::BUF_SEL_LSB];
    assign rd_idx = a_off[arf_pkg::BUF_IDX_LSB +: arf_pkg::BUF_IDX_W];
    assign cur_code = buf_mem[rd_idx];

    // Formatting happens on the read path only
    assign fmt_bus.code = cur_code;
    assign fmt_bus.fmt = fmt;

    assign ctrl1_view = (32'(fmt) << arf_pkg::CTRL1_FMT_LSB)
                        | (32'(SAMPLE_HOLD) << arf_pkg::CTRL1_SAMPLE_CONTROL_BIT_BIT)
                        | (32'(done) << arf_pkg::CTRL1_DONE_BIT);
    assign ctrl3_view = 32'(auto_sample_duration) << arf_pkg::CTRL3_ASD_LSB;

    // Unmapped offsets read zero with an OKAY answer
    assign rd_mux = hit_buf ? {16'h0000, fmt_bus.word} :
                    (a_off == arf_pkg::OFF_CTRL1) ? ctrl1_view :
                    (a_off == arf_pkg::OFF_CTRL3) ? ctrl3_view :
                    (a_off == arf_pkg::OFF_STATUS) ? 32'(irq_status) :
                    (a_off == arf_pkg::OFF_MASK) ? 32'(irq_mask) : 32'h0000_0000;

    // Data phase write decode
    assign wr_ctrl1 = wr_pend & (wr_off == arf_pkg::OFF_CTRL1);
    assign wr_ctrl3 = wr_pend & (wr_off == arf_pkg::OFF_CTRL3);
    assign wr_status = wr_pend & (wr_off == arf_pkg::OFF_STATUS);
    assign wr_mask = wr_pend & (wr_off == arf_pkg::OFF_MASK);

    // Setting the bit only starts sampling from idle; the duration field plays no part
    assign sample_control_bit_set = wr_ctrl1 & HWDATA[arf_pkg::CTRL1_SAMPLE_CONTROL_BIT_BIT]
                      & (state == arf_pkg::ARF_IDLE);
    assign sample_control_bit_clear = wr_ctrl1 & ~HWDATA[arf_pkg::CTRL1_SAMPLE_CONTROL_BIT_BIT]
                        & (state == arf_pkg::ARF_SAMPLE);
    assign conv_evt = (state == arf_pkg::ARF_CONVERT) & CONV_DONE;

    // Hardware set wins over the software clear
    assign next_done = conv_evt | (done & ~sample_control_bit_set);
    assign next_status = conv_evt
                         | (irq_status & ~(wr_status & HWDATA[arf_pkg::IRQ_CONV_BIT]));

    always_comb
    begin
        next_state = state;
        unique case (state)
            arf_pkg::ARF_IDLE:
            begin
                if (sample_control_bit_set)
                begin
                    next_state = arf_pkg::ARF_SAMPLE;
                end
            end
            arf_pkg::ARF_SAMPLE:
            begin
                if (sample_control_bit_clear)
                begin
                    next_state = arf_pkg::ARF_CONVERT;
                end
            end
            arf_pkg::ARF_CONVERT:
            begin
                if (CONV_DONE)
                begin
                    next_state = arf_pkg::ARF_IDLE;
                end
            end
            // Fourth code of the state register is unused
            default:
            begin
                next_state = arf_pkg::ARF_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state <= arf_pkg::ARF_IDLE;
            SAMPLE_HOLD <= 1'b0;
            CONV_START <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            state <= next_state;
            SAMPLE_HOLD <= (next_state == arf_pkg::ARF_SAMPLE);
            CONV_START <= sample_control_bit_clear;
            done <= next_done;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            fmt <= arf_pkg::FMT_RESET;
            auto_sample_duration <= '0;
            irq_status <= 1'b0;
            irq_mask <= 1'b0;
            IRQ <= 1'b0;
        end
        else
        begin
            if (wr_ctrl1)
            begin
                fmt <= arf_pkg::arf_fmt_t'(HWDATA[arf_pkg::CTRL1_FMT_LSB +: 2]);
            end
            if (wr_ctrl3)
            begin
                auto_sample_duration <= HWDATA[arf_pkg::CTRL3_ASD_LSB +: arf_pkg::ASD_W];
            end
            if (wr_mask)
            begin
                irq_mask <= HWDATA[arf_pkg::IRQ_CONV_BIT];
            end
            irq_status <= next_status;
            IRQ <= irq_status & irq_mask;
        end
    end

    // Zero wait states: read data is registered in the address phase
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            HRDATA <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            wr_pend <= 1'b0;
            wr_off <= '0;
        end
        else
        begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            wr_pend <= addr_take & HWRITE;
            wr_off <= a_off;
            if (rd_take)
            begin
                HRDATA <= rd_mux;
            end
        end
    end

    // Stored codes are written only by a completed conversion
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            wr_ptr <= '0;
        end
        else if (conv_evt)
        begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (conv_evt)
        begin
            buf_mem[wr_ptr] <= CONV_DATA;
        end
    end

    sequence s_buf_read(arf_pkg::arf_fmt_t f);
        rd_take && hit_buf && fmt == f;
    endsequence

    sequence s_sample_control_bit_clear;
        state == arf_pkg::ARF_SAMPLE && wr_ctrl1 && !HWDATA[arf_pkg::CTRL1_SAMPLE_CONTROL_BIT_BIT];
    endsequence

    property p_word16;
        @(posedge CLK) disable iff (RST)
        rd_take && hit_buf |=> HRDATA[31:16] == 16'h0000;
    endproperty
    a_word16: assert property (p_word16) else $error("buffer read wider than 16 bits");

    property p_uint;
        @(posedge CLK) disable iff (RST)
        s_buf_read(arf_pkg::ARF_FMT_UINT)
        |=> HRDATA[15:0] == {arf_pkg::PAD_ZERO, $past(cur_code)};
    endproperty
    a_uint: assert property (p_uint) else $error("unsigned integer read wrong");

    property p_sint;
        @(posedge CLK) disable iff (RST)
        s_buf_read(arf_pkg::ARF_FMT_SINT)
        |=> HRDATA[15:0] == 16'({arf_pkg::PAD_ZERO, $past(cur_code)} - arf_pkg::SINT_OFFSET);
    endproperty
    a_sint: assert property (p_sint) else $error("signed integer read wrong");

    property p_frac;
        @(posedge CLK) disable iff (RST)
        s_buf_read(arf_pkg::ARF_FMT_FRAC)
        |=> HRDATA[15:6] == $past(cur_code) && HRDATA[5:0] == arf_pkg::PAD_ZERO;
    endproperty
    a_frac: assert property (p_frac) else $error("fractional read wrong");

    property p_sfrac;
        @(posedge CLK) disable iff (RST)
        s_buf_read(arf_pkg::ARF_FMT_SFRAC)
        |=> HRDATA[15] != $past(cur_code[9]) && HRDATA[14:6] == $past(cur_code[8:0])
            && HRDATA[5:0] == arf_pkg::PAD_ZERO;
    endproperty
    a_sfrac: assert property (p_sfrac) else $error("signed fractional read wrong");

    property p_hold_sample;
        @(posedge CLK) disable iff (RST)
        state == arf_pkg::ARF_SAMPLE && !sample_control_bit_clear |=> state == arf_pkg::ARF_SAMPLE;
    endproperty
    a_hold_sample: assert property (p_hold_sample) else $error("sampling ended by itself");

    property p_clear_converts;
        @(posedge CLK) disable iff (RST)
        s_sample_control_bit_clear |=> CONV_START && !SAMPLE_HOLD ##1 !CONV_START;
    endproperty
    a_clear_converts: assert property (p_clear_converts) else $error("no start on clear");

    property p_complete;
        @(posedge CLK) disable iff (RST)
        conv_evt |=> done && irq_status && state == arf_pkg::ARF_IDLE;
    endproperty
    a_complete: assert property (p_complete) else $error("completion flags not set");

    property p_irq_each;
        @(posedge CLK) disable iff (RST)
        conv_evt && irq_mask ##1 irq_mask |=> IRQ;
    endproperty
    a_irq_each: assert property (p_irq_each) else $error("no interrupt after a result");

    property p_fmt_keeps_data;
        @(posedge CLK) disable iff (RST)
        wr_ctrl1 && !conv_evt |=> $stable(buf_mem[0]) && $stable(wr_ptr);
    endproperty
    a_fmt_keeps_data: assert property (p_fmt_keeps_data) else $error("stored code altered");
endmodule : arf_top

//--- testbench/test_adc_result_format_and_manual_sampling.sv
/*
 * Self-checking bench for the result-format and manual-sampling block.
 * Assumes the block is the only AHB-Lite slave, so its ready output is fed back as bus ready.
 */
`timescale 1ns/1ps
module test_adc_result_format_and_manual_sampling;
    logic clk;
    logic rst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic sample_hold;
    logic conv_start;
    logic conv_done;
    logic [9:0] conv_data;
    logic irq;
    int n_fail;
    int num_checks;

    arf_top arf_top_i (
        .CLK(clk),
        .RST(rst),
        .HSEL(hsel),
        .HADDR(haddr),
        .HTRANS(htrans),
        .HWRITE(hwrite),
        .HSIZE(3'h2),
        .HWDATA(hwdata),
        .HREADY(hreadyout),
        .HRDATA(hrdata),
        .HREADYOUT(hreadyout),
        .HRESP(hresp),
        .SAMPLE_HOLD(sample_hold),
        .CONV_START(conv_start),
        .CONV_DONE(conv_done),
        .CONV_DATA(conv_data),
        .IRQ(irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    // One single-word transfer; waits on ready, so no wait-state count is assumed
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {20'h00000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    // Reference formatting, worked out independently of the design
    function automatic logic [31:0] fmt_exp(input logic [9:0] c, input logic [1:0] f);
        case (f)
            2'h0: fmt_exp = {22'h000000, c};
            2'h1: fmt_exp = {16'h0000, 16'({6'h00, c}) - 16'h0200};
            2'h2: fmt_exp = {16'h0000, c, 6'h00};
            default: fmt_exp = {16'h0000, 16'(({6'h00, c} - 16'h0200) << 6)};
        endcase
    endfunction : fmt_exp

    // Full manual sample/convert sequence with one result from the core
    task automatic conv(input logic [9:0] c, input logic m);
        logic [31:0] r;
        int n;
        bus(1'b1, arf_pkg::OFF_CTRL1, 32'h00000002, r);
        n = 0;
        repeat (40)
        begin
            @(posedge clk);
            n += conv_start;
        end
        check("sample_hold_high", {31'h0, sample_hold}, 32'h1);
        check("no_auto_end", 32'(n), 32'h0);
        bus(1'b0, arf_pkg::OFF_CTRL1, 32'h0, r);
        check("done_while_sampling", {30'h0, r[1:0]}, 32'h2);
        bus(1'b1, arf_pkg::OFF_CTRL1, 32'h00000000, r);
        n = 0;
        repeat (4)
        begin
            @(posedge clk);
            n += conv_start;
        end
        check("start_pulses", 32'(n), 32'h1);
        check("sample_hold_low", {31'h0, sample_hold}, 32'h0);
        @(posedge clk);
        conv_done <= 1'b1;
        conv_data <= c;
        @(posedge clk);
        conv_done <= 1'b0;
        // Stale data would hide a late capture, so the bus shows its inverse
        conv_data <= ~c;
        repeat (3) @(posedge clk);
        bus(1'b0, arf_pkg::OFF_CTRL1, 32'h0, r);
        check("done_bit", {31'h0, r[0]}, 32'h1);
        bus(1'b0, arf_pkg::OFF_STATUS, 32'h0, r);
        check("irq_status", r, 32'h1);
        check("irq_level", {31'h0, irq}, {31'h0, m});
        bus(1'b1, arf_pkg::OFF_STATUS, 32'h00000001, r);
        repeat (3) @(posedge clk);
        check("irq_cleared", {31'h0, irq}, 32'h0);
    endtask : conv

    task automatic t_reset;
        check("hrdata_rst", hrdata, 32'h0);
        check("outs_rst", {28'h0, hreadyout, hresp, sample_hold, irq}, 32'h8);
        $display("test reset done");
    endtask : t_reset

    task automatic t_manual;
        logic [31:0] r;
        bus(1'b1, arf_pkg::OFF_CTRL3, 32'h00001f00, r);
        bus(1'b0, arf_pkg::OFF_CTRL3, 32'h0, r);
        check("ctrl3_rw", r, 32'h00001f00);
        conv(10'h155, 1'b0);
        bus(1'b1, arf_pkg::OFF_MASK, 32'h00000001, r);
        conv(10'h2aa, 1'b1);
        $display("test manual done");
    endtask : t_manual

    task automatic t_formats;
        logic [31:0] r;
        logic [9:0] cs [4];
        cs = '{10'h3ff, 10'h200, 10'h1ff, 10'h000};
        for (int i = 0; i < 4; i++)
            conv(cs[i], 1'b1);
        for (int f = 0; f < 4; f++)
        begin
            bus(1'b1, arf_pkg::OFF_CTRL1, 32'(f) << 8, r);
            bus(1'b0, arf_pkg::OFF_CTRL1, 32'h0, r);
            check("format_field", {30'h0, r[9:8]}, 32'(f));
            for (int i = 0; i < 4; i++)
            begin
                bus(1'b0, arf_pkg::OFF_BUF + 12'(4 * (i + 2)), 32'h0, r);
                check("buffer_word", r, fmt_exp(cs[i], 2'(f)));
            end
        end
        bus(1'b1, arf_pkg::OFF_CTRL1, 32'h0, r);
        bus(1'b0, arf_pkg::OFF_BUF, 32'h0, r);
        check("entry0", r, 32'h00000155);
        bus(1'b0, arf_pkg::OFF_BUF + 12'h004, 32'h0, r);
        check("entry1", r, 32'h000002aa);
        $display("test formats done");
    endtask : t_formats

    task automatic t_unmapped;
        logic [31:0] r;
        bus(1'b0, 12'h100, 32'h0, r);
        check("unmapped_read", r, 32'h0);
        $display("test unmapped done");
    endtask : t_unmapped

    initial
    begin
        n_fail = 0;
        num_checks = 0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        conv_done = 1'b0;
        conv_data = 10'h000;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_manual();
        t_formats();
        t_unmapped();
        complete_run();
    end

    // Roughly forty times the expected run length
    initial
    begin
        #400000;
        n_fail++;
        complete_run();
    end
endmodule : test_adc_result_format_and_manual_sampling
